// ==== wdt_map.vh ====
// Purpose: constants for the watchdog and halt/wake-up block
// Assumes: AHB-Lite word registers, 200 MHz hclk
// Notes:   offsets are byte addresses
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define OFS_WDT_CTRL     8'h00
`define OFS_RST_FLAGS    8'h04
`define OFS_CLK_CTRL     8'h08
`define OFS_WAKE_EN      8'h0C
`define OFS_STATUS       8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_MASK     8'h18

`define WDT_CTRL_RESET   8'h53
`define GUARD_A          5'h15
`define GUARD_B          5'h0A
`define GUARD_MSB        7
`define GUARD_LSB        3
`define PERIOD_MSB       2

// software reset delay in ns, held as cycles of hclk
`define SRESET_DELAY_NS  1000
`define CLK_PERIOD_NS    5
`define SRESET_CYCLES    ((`SRESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define MODE_RUN         2'h0
`define MODE_SLEEP       2'h1
`define MODE_IDLE_FAST   2'h2
`define MODE_IDLE_BOTH   2'h3

`define EV_WAKE          0
`define EV_OVF           1
`define EV_GUARD         2

`endif

// ==== wdt_halt_wakeup.v ====
// Purpose: watchdog timer with halt mode entry and wake-up control
// Assumes: slow oscillator arrives as a one-cycle tick synchronous to hclk
// Notes:   device resets are pulses; the core acts on them
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.vh"

module wdt_halt_wakeup #(
  parameter [15:0] SRESET_CYCLES = `SRESET_CYCLES
) (
  // system
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // core
  input  wire        halt_exec,
  input  wire        clear_watchdog_instruction,
  input  wire        slow_tick,
  input  wire [7:0]  port_a_in,
  input  wire        irq_request,
  input  wire        irq_enabled,
  input  wire        stack_full,
  // results
  output reg  [1:0]  power_mode,
  output reg         fast_clock_run,
  output reg         slow_clock_run,
  output reg         wake_resume,
  output reg         wake_to_irq,
  output reg         pc_sp_reset,
  output reg         device_reset,
  output reg         power_down_flag,
  output reg         timeout_flag,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////
  // overview of operation
  //
  // register bus
  //   single-word transfers, no wait states
  //   read data captured at the address phase edge
  //   so it stands for the whole data phase
  //   write data taken at the end of the data phase
  //   unmapped offsets read zero, writes ignored
  //
  // halt entry
  //   taken only while running; a halted core issues nothing
  //   the two keep bits pick the low-power mode
  //   both set: both clocks stay on
  //   fast only: slow clock stops
  //   neither: sleep, both clocks stop
  //   slow only: reported as sleep in this block, slow clock kept on,
  //   since no separate mode output exists for it
  //   entry sets the power-down flag, clears timeout
  //   entry clears the watchdog counter
  //
  // watchdog counter
  //   advances on the slow tick only while the slow clock runs
  //   a stopped slow clock means no source, so no count
  //   overflow when count plus one reaches the selected bit
  //   the counter wraps to zero on overflow
  //   cleared by the clear instruction, halt entry,
  //   and by a control write with a bad guard value
  //
  // wake-up
  //   pin falls with its enable bit set
  //   interrupt request armed at entry
  //   a request already high at entry stays disarmed,
  //   so it cannot wake the core during that halt
  //   overflow while halted wakes and resets pc and sp
  //   one result pulse per wake, chosen by priority:
  //   overflow first, then interrupt entry, then resume
  //
  // running overflow
  //   full device reset pulse and timeout flag set
  //
  // guard field
  //   any value but the two enabling codes starts a delay
  //   the delay ends in a device reset pulse
  //   the register reset flag is set at the same time
  //   the bad value stays stored; software must restore it
  //   the flag clears only by software writing zero
  //   a set in the same cycle as a clear wins
  //
  // interrupt status
  //   three sticky bits: wake, overflow, guard reset
  //   write one to clear, an event in the same cycle wins
  //   irq output high while an unmasked bit is set
  //
  // limitations
  //   device resets are pulses only; the core acts on them
  //   the delay count is a parameter so a bench can shorten it
  //   port states and memory are untouched by this block
  //
  // timing
  //   halt strobe at edge n gives the new mode at n+1
  //   a wake event at edge m gives run mode at m+1
  //   result pulses last exactly one cycle

  ////////////////////////////////////////////////////////////////
  // registers and state
  reg [7:0]  watchdog_control;
  reg [1:0]  system_clock_control;   // bit1 fast keep, bit0 slow keep
  reg [7:0]  port_a_wake_enable;
  reg        watchdog_register_reset_flag;
  reg [2:0]  irq_status;
  reg [2:0]  irq_mask;
  reg [17:0] wdt_count;
  reg [15:0] sreset_count;
  reg        sreset_pending;
  reg [7:0]  port_a_prev;
  reg        irq_armed;
  reg        dph_write;
  reg [7:0]  dph_addr;

  wire        fast_keep = system_clock_control[1];
  wire        slow_keep = system_clock_control[0];
  wire [4:0]  guard_field = watchdog_control[`GUARD_MSB:`GUARD_LSB];
  wire [2:0]  period_select = watchdog_control[`PERIOD_MSB:0];
  wire        halted = (power_mode != `MODE_RUN);

  // overflow bit index per period selection
  function [4:0] ovf_bit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    ovf_bit = 5'h08;
        3'h1:    ovf_bit = 5'h0A;
        3'h2:    ovf_bit = 5'h0C;
        3'h3:    ovf_bit = 5'h0E;
        3'h4:    ovf_bit = 5'h0F;
        3'h5:    ovf_bit = 5'h10;
        3'h6:    ovf_bit = 5'h11;
        default: ovf_bit = 5'h12;
      endcase
    end
  endfunction

  function guard_ok;
    input [4:0] g;
    begin
      guard_ok = (g == `GUARD_A) || (g == `GUARD_B);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus decode
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_now = dph_write;
  wire [7:0] wdata8 = hwdata[7:0];
  wire ctrl_wr = wr_now && (dph_addr == `OFS_WDT_CTRL);
  wire bad_guard_wr = ctrl_wr && !guard_ok(wdata8[7:3]);

  // combinational overflow and wake events
  wire [18:0] count_ext = {1'b0, wdt_count} + 19'h00001;
  // low-speed clock stops in a halt unless the slow keep bit is set; watchdog only ticks when it runs
  wire slow_clock_ok = !halted || slow_keep;
  wire overflow = slow_tick && slow_clock_ok && count_ext[ovf_bit(period_select)];
  wire pin_wake = |(port_a_prev & ~port_a_in & port_a_wake_enable);
  wire irq_wake = irq_request && irq_armed;
  wire any_wake = halted && (pin_wake || irq_wake || overflow);

  ////////////////////////////////////////////////////////////////
  // ahb data phase tracking, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dph_write <= addr_phase && hwrite;
      if (addr_phase) begin
        dph_addr <= haddr[7:0];
      end
      // read data is latched at the address phase so it stands during data phase
      if (addr_phase && !hwrite) begin
        case (haddr[7:0])
          `OFS_WDT_CTRL:   hrdata <= {24'h000000, watchdog_control};
          `OFS_RST_FLAGS:  hrdata <= {31'h00000000, watchdog_register_reset_flag};
          `OFS_CLK_CTRL:   hrdata <= {30'h00000000, system_clock_control};
          `OFS_WAKE_EN:    hrdata <= {24'h000000, port_a_wake_enable};
          `OFS_STATUS:     hrdata <= {28'h0000000, power_mode, timeout_flag, power_down_flag};
          `OFS_IRQ_STATUS: hrdata <= {29'h00000000, irq_status};
          `OFS_IRQ_MASK:   hrdata <= {29'h00000000, irq_mask};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_control     <= `WDT_CTRL_RESET;
      system_clock_control <= 2'h0;
      port_a_wake_enable   <= 8'h00;
      irq_mask             <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        watchdog_control <= wdata8;
      end
      if (wr_now && dph_addr == `OFS_CLK_CTRL) begin
        system_clock_control <= wdata8[1:0];
      end
      if (wr_now && dph_addr == `OFS_WAKE_EN) begin
        port_a_wake_enable <= wdata8;
      end
      if (wr_now && dph_addr == `OFS_IRQ_MASK) begin
        irq_mask <= wdata8[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // watchdog counter on the slow tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_count <= 18'h00000;
    end else if (bad_guard_wr || clear_watchdog_instruction || (halt_exec && !halted)) begin
      wdt_count <= 18'h00000;
    end else if (overflow) begin
      wdt_count <= 18'h00000;
    end else if (slow_tick && slow_clock_ok) begin
      wdt_count <= count_ext[17:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // delayed reset for an invalid guard value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sreset_pending <= 1'b0;
      sreset_count   <= 16'h0000;
    end else if (bad_guard_wr) begin
      sreset_pending <= 1'b1;
      sreset_count   <= SRESET_CYCLES;
    end else if (sreset_pending) begin
      if (sreset_count <= 16'h0001) begin
        sreset_pending <= 1'b0;
      end
      sreset_count <= sreset_count - 16'h0001;
    end
  end

  wire sreset_fire = sreset_pending && (sreset_count <= 16'h0001);

  ////////////////////////////////////////////////////////////////
  // halt mode and flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_mode      <= `MODE_RUN;
      fast_clock_run  <= 1'b1;
      slow_clock_run  <= 1'b1;
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b0;
      wake_resume     <= 1'b0;
      wake_to_irq     <= 1'b0;
      pc_sp_reset     <= 1'b0;
      device_reset    <= 1'b0;
      irq_armed       <= 1'b0;
      port_a_prev     <= 8'hFF;
      watchdog_register_reset_flag <= 1'b0;
    end else begin
      port_a_prev  <= port_a_in;
      wake_resume  <= 1'b0;
      wake_to_irq  <= 1'b0;
      pc_sp_reset  <= 1'b0;
      device_reset <= 1'b0;
      if (halt_exec && !halted) begin
        case ({fast_keep, slow_keep})
          2'b11:   power_mode <= `MODE_IDLE_BOTH;
          2'b10:   power_mode <= `MODE_IDLE_FAST;
          default: power_mode <= `MODE_SLEEP;
        endcase
        fast_clock_run  <= fast_keep;
        slow_clock_run  <= slow_keep;
        power_down_flag <= 1'b1;
        timeout_flag    <= 1'b0;
        irq_armed       <= !irq_request;
      end else if (any_wake) begin
        power_mode     <= `MODE_RUN;
        fast_clock_run <= 1'b1;
        slow_clock_run <= 1'b1;
        if (overflow) begin
          timeout_flag <= 1'b1;
          pc_sp_reset  <= 1'b1;
        end else if (irq_wake && irq_enabled && !stack_full) begin
          wake_to_irq <= 1'b1;
        end else begin
          wake_resume <= 1'b1;
        end
      end else if (overflow && !halted) begin
        timeout_flag <= 1'b1;
        device_reset <= 1'b1;
      end
      if (clear_watchdog_instruction && !(halt_exec && !halted)) begin
        power_down_flag <= 1'b0;
      end
      if (sreset_fire) begin
        device_reset <= 1'b1;
      end
      // set wins over a software clear
      if (sreset_fire) begin
        watchdog_register_reset_flag <= 1'b1;
      end else if (wr_now && dph_addr == `OFS_RST_FLAGS && !wdata8[0]) begin
        watchdog_register_reset_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins
  wire [2:0] ev = {sreset_fire, overflow, any_wake};
  wire [2:0] w1c = (wr_now && dph_addr == `OFS_IRQ_STATUS) ? wdata8[2:0] : 3'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~w1c) | ev;
      irq        <= |(((irq_status & ~w1c) | ev) & irq_mask);
    end
  end

endmodule // wdt_halt_wakeup
`default_nettype wire

// ==== wdt_halt_wakeup_props.sv ====
// Purpose: port assertions for the watchdog and halt/wake block
// Assumes: one clock domain, async active-low reset
// Notes:   bound into every design instance
`timescale 1ns/100ps
`default_nettype none
module wdt_halt_wakeup_chk #(
  parameter [15:0] SRESET_CYCLES = 16'h0004
) (
  // system
  input wire logic       hclk,
  input wire logic       hresetn,
  // core side
  input wire logic       halt_exec,
  input wire logic       clear_watchdog_instruction,
  input wire logic       irq_enabled,
  input wire logic       stack_full,
  // results
  input wire logic [1:0] power_mode,
  input wire logic       fast_clock_run,
  input wire logic       slow_clock_run,
  input wire logic       wake_resume,
  input wire logic       wake_to_irq,
  input wire logic       pc_sp_reset,
  input wire logic       power_down_flag,
  input wire logic       timeout_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // mode entry and clock gating
  AST_HALT_FLAGS: assert property (halt_exec && power_mode == 2'h0 |=> power_down_flag && !timeout_flag)
    else $error("halt entry flags wrong");
  AST_IDLE_BOTH: assert property (power_mode == 2'h3 |-> fast_clock_run && slow_clock_run)
    else $error("idle both clocks wrong");
  AST_IDLE_FAST: assert property (power_mode == 2'h2 |-> fast_clock_run && !slow_clock_run)
    else $error("idle fast clocks wrong");
  AST_SLEEP: assert property (power_mode == 2'h1 |-> !fast_clock_run && !slow_clock_run)
    else $error("sleep clocks wrong");
  // clear wins only when no halt competes for the flag
  AST_CLEAR_PD: assert property (clear_watchdog_instruction && !halt_exec |=> !power_down_flag)
    else $error("power-down flag not cleared");
  ////////////////////////////////////////////////////////////
  // wake-up
  AST_WAKE_EXIT: assert property ($rose(wake_resume) |-> power_mode == 2'h0 && $past(power_mode) != 2'h0)
    else $error("resume without halted mode");
  AST_WAKE_PULSE: assert property (wake_resume |=> !wake_resume)
    else $error("resume pulse too long");
  AST_IRQ_WAKE: assert property (wake_to_irq |-> $past(irq_enabled) && !$past(stack_full))
    else $error("interrupt entry not allowed");
  AST_OVF_HALTED: assert property (pc_sp_reset |-> $past(power_mode) != 2'h0 && power_down_flag ##1 timeout_flag)
    else $error("halted overflow wrong");
endmodule // wdt_halt_wakeup_chk
bind wdt_halt_wakeup wdt_halt_wakeup_chk #(.SRESET_CYCLES(SRESET_CYCLES)) chk (.hclk, .hresetn, .halt_exec,
  .clear_watchdog_instruction, .irq_enabled, .stack_full, .power_mode, .fast_clock_run, .slow_clock_run,
  .wake_resume, .wake_to_irq, .pc_sp_reset, .power_down_flag, .timeout_flag);
`default_nettype wire

// ==== core_model.sv ====
// Purpose: processor core issuing halt and clear strobes
// Assumes: bench raises requests for one cycle
// Notes:   also makes the slow oscillator tick
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // clock and state
  input  wire logic       hclk,
  input  wire logic [1:0] power_mode,
  // requests from the bench
  input  wire logic       want_halt,
  input  wire logic       want_clear,
  input  wire logic       tick_en,
  // strobes
  output var logic        halt_exec,
  output var logic        clear_watchdog_instruction,
  output var logic        slow_tick
);
  initial {halt_exec, clear_watchdog_instruction, slow_tick} = 3'h0;
  // a halted core fetches nothing, so halt only while running
  always @(posedge hclk) begin
    halt_exec <= want_halt && power_mode == 2'h0;
    clear_watchdog_instruction <= want_clear;
    slow_tick <= tick_en && !slow_tick;
  end
endmodule // core_model
`default_nettype wire

// ==== tb_watchdog_and_halt_wakeup.sv ====
// Purpose: self-checking bench for the watchdog and halt/wake block
// Assumes: zero-wait slave, short software reset delay
// Notes:   core model drives the instruction strobes
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.vh"
module tb_watchdog_and_halt_wakeup;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, want_halt = 0, want_clear = 0, tick_en = 0;
  logic        irq_request = 0, irq_enabled = 0, stack_full = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  port_a_in = 8'hFF;
  logic [31:0] haddr = 0, hwdata = 0, q;
  wire  [31:0] hrdata;
  wire  [1:0]  power_mode;
  wire         hreadyout, hresp, fast_clock_run, slow_clock_run, wake_resume, wake_to_irq, pc_sp_reset;
  wire         device_reset, power_down_flag, timeout_flag, irq, halt_exec, clear_watchdog_instruction, slow_tick;
  wire         hready = hreadyout;
  wire  [3:0]  pulses = {device_reset, pc_sp_reset, wake_to_irq, wake_resume};
  int          failures = 0, cmp_count = 0, seed = 32'ha7f7, n, i, em;
  int          ks[3] = '{3, 2, 0};
  wdt_halt_wakeup #(.SRESET_CYCLES(16'h0004)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .halt_exec, .clear_watchdog_instruction, .slow_tick, .port_a_in,
    .irq_request, .irq_enabled, .stack_full, .power_mode, .fast_clock_run, .slow_clock_run, .wake_resume,
    .wake_to_irq, .pc_sp_reset, .device_reset, .power_down_flag, .timeout_flag, .irq);
  core_model core (.hclk, .power_mode, .want_halt, .want_clear, .tick_en, .halt_exec, .clear_watchdog_instruction,
    .slow_tick);
  ////////////////////////////////////////////////////////////
  always #2.5 hclk = ~hclk;
  task test_done;
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one word transfer, holding each phase until hready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
    chk(hresp, 0);
  endtask
  // bounded wait on one result pulse; n keeps the cycle count
  task wt(input int b, input int lim);
    n = 0;
    while (pulses[b] !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(pulses[b], 1);
  endtask
  task halt;
    want_halt <= 1'b1;
    @(posedge hclk);
    want_halt <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task pin_wake;
    port_a_in <= 8'hFE;
    wt(0, 20);
    port_a_in <= 8'hFF;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_WDT_CTRL, 32'h53);
    rd(8'h1C, 32'h0);
    xfer(1'b1, `OFS_CLK_CTRL, 32'h3);
    xfer(1'b1, `OFS_WAKE_EN, $random(seed) & 32'hFE);
    halt;
    port_a_in <= 8'hFE;
    repeat (8) @(posedge hclk);
    chk(power_mode, 3);
    port_a_in <= 8'hFF;
    xfer(1'b1, `OFS_WAKE_EN, 32'h1);
    for (i = 0; i < 3; i++) begin
      if (i > 0) begin
        xfer(1'b1, `OFS_CLK_CTRL, ks[i]);
        halt;
      end
      em = ks[i] == 3 ? 3 : ks[i] == 2 ? 2 : 1;
      chk(power_mode, em);
      rd(`OFS_STATUS, em * 4 + 1);
      pin_wake;
      chk(power_mode, 0);
    end
    want_clear <= 1'b1;
    @(posedge hclk);
    want_clear <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(`OFS_STATUS, 32'h0);
    irq_enabled <= 1'b1;
    for (i = 0; i < 2; i++) begin
      stack_full <= i[0];
      halt;
      irq_request <= 1'b1;
      wt(1 - i, 20);
      irq_request <= 1'b0;
      @(posedge hclk);
    end
    irq_request <= 1'b1;
    halt;
    repeat (8) @(posedge hclk);
    chk(power_mode, 1);
    pin_wake;
    irq_request <= 1'b0;
    xfer(1'b1, `OFS_WDT_CTRL, 32'h50);
    xfer(1'b1, `OFS_CLK_CTRL, 32'h3);
    tick_en <= 1'b1;
    repeat (400) @(posedge hclk);
    halt;
    wt(2, 1000);
    chk(n > 400 && n < 530, 1);
    @(posedge hclk);
    chk(timeout_flag, 1);
    wt(3, 1100);
    @(posedge hclk);
    chk(timeout_flag, 1);
    tick_en <= 1'b0;
    xfer(1'b1, `OFS_WDT_CTRL, 32'h00);
    wt(3, 20);
    chk(n > 2 && n < 8, 1);
    rd(`OFS_RST_FLAGS, 32'h1);
    xfer(1'b1, `OFS_RST_FLAGS, 32'h0);
    rd(`OFS_RST_FLAGS, 32'h0);
    xfer(1'b1, `OFS_WDT_CTRL, 32'h53);
    rd(`OFS_IRQ_STATUS, 32'h7);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk(irq, 0);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge hclk);
    chk(irq, 1);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h7);
    rd(`OFS_IRQ_STATUS, 32'h0);
    chk(irq, 0);
    test_done;
  end
  // hang guard, well past the longest expected run
  initial begin
    #60000;
    failures++;
    test_done;
  end
endmodule // tb_watchdog_and_halt_wakeup
`default_nettype wire
